// ---- logic/peripheral_access_timing.sv ----
/*
  peripheral_access_timing: takes one access from an upstream master,
  decodes its region, waits the region's cycle count (plus clock-ratio
  sync, wide-register and port read-wait extras), then forwards it to
  the downstream register banks and answers in one handshake.
  assumes: one clock; pclk_tick marks a peripheral clock b edge in the
  core clock domain; pclk_equal high when both clocks run equal.
*/
`timescale 1ns/1ps
`default_nettype none

module peripheral_access_timing (
  input  wire logic                          clock,        // core clock
  input  wire logic                          resetn,       // async, low
  input  wire logic                          pclk_tick,    // pclk b edge
  input  wire logic                          pclk_equal,   // clocks equal
  input  wire logic                          contention,   // other master
  input  wire logic [3:0]                    port_read_wait_count, // wait
  input  wire logic                          req_valid,    // request
  input  wire access_timing_pkg::request_type req,         // request body
  output logic                               req_ready,    // taken
  output logic                               ans_valid,    // answer pulse
  output access_timing_pkg::answer_type      ans,          // answer body
  output logic                               dn_strobe,    // bank strobe
  output access_timing_pkg::request_type     dn_req,       // bank request
  input  wire logic [31:0]                   dn_rdata      // bank data
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle = 3'b001,  // waiting for a request
    st_wait = 3'b010,  // counting access cycles
    st_done = 3'b100   // answering
  } state_type;

  state_type                          state_reg;      // current state
  access_timing_pkg::request_type     hold_reg;       // captured access
  access_timing_pkg::region_type      region_reg;     // captured region
  logic                               use_pclk_reg;   // count pclk ticks
  logic [3:0]                         count_reg;      // cycles remaining
  access_timing_pkg::region_type      region_dec;     // live decode
  logic                               port_win_dec;   // live port window
  logic [3:0]                         load_count;     // first count
  logic                               tick_now;       // counts this cycle

  region_decoder u_decode (
    .addr        (req.addr),
    .region      (region_dec),
    .port_window (port_win_dec)
  );

  // ------------------------------------------------------------------
  // count to load when an access is taken
  // ------------------------------------------------------------------
  // the faster-core case uses the upper end of the 2 to 4 span: the
  // sync stage always spends at least one extra pclk, and the rounded-up
  // maximum is the safe bound for a master that waits in hardware
  always_comb begin
    load_count = access_timing_pkg::count_reset;
    case (region_dec)
      access_timing_pkg::reg_syslow:
        load_count = access_timing_pkg::sys_low_cycles;
      access_timing_pkg::reg_sysctl:
        load_count = access_timing_pkg::sysctl_cycles;
      access_timing_pkg::reg_port,
      access_timing_pkg::reg_perif: begin
        if (pclk_equal) begin
          load_count = access_timing_pkg::pclk_eq_cycles;
        end else begin
          load_count = access_timing_pkg::pclk_fast_max;
        end
        if (region_dec == access_timing_pkg::reg_port && port_win_dec &&
            !req.write) begin
          load_count = 4'(load_count + port_read_wait_count);
        end
      end
      default: load_count = access_timing_pkg::sys_low_cycles;
    endcase
    if (req.wide) begin
      load_count = 4'(load_count + access_timing_pkg::wide_reg_extra);
    end
  end

  // low regions count core clocks, peripheral regions count pclk b
  // edges; contention freezes the count, so accesses only lengthen
  assign tick_now = !contention &&
                    (!use_pclk_reg || pclk_equal || pclk_tick);

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= st_idle;
    end else begin
      case (state_reg)
        st_idle: if (req_valid) state_reg <= st_wait;
        st_wait: if (tick_now && count_reg == 4'h1) state_reg <= st_done;
        st_done: state_reg <= st_idle;
        default: state_reg <= st_idle;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // captured access and counter
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_reg     <= '0;
      region_reg   <= access_timing_pkg::reg_none;
      use_pclk_reg <= 1'b0;
      count_reg    <= access_timing_pkg::count_reset;
    end else if (state_reg == st_idle && req_valid) begin
      hold_reg     <= req;
      region_reg   <= region_dec;
      use_pclk_reg <= (region_dec == access_timing_pkg::reg_port ||
                       region_dec == access_timing_pkg::reg_perif);
      // first wait cycle is the capture cycle itself
      count_reg    <= load_count - 4'h1;
    end else if (state_reg == st_wait && tick_now &&
                 count_reg != access_timing_pkg::count_reset) begin
      count_reg    <= count_reg - 4'h1;
    end
  end

  // ------------------------------------------------------------------
  // handshake outputs, all registered
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      req_ready <= 1'b0;
      ans_valid <= 1'b0;
      ans       <= '0;
      dn_strobe <= 1'b0;
      dn_req    <= '0;
    end else begin
      req_ready <= (state_reg == st_idle && req_valid);
      dn_strobe <= (state_reg == st_wait && tick_now &&
                    count_reg == 4'h1);
      ans_valid <= (state_reg == st_done);
      if (state_reg == st_wait) begin
        dn_req <= hold_reg;
      end
      if (state_reg == st_done) begin
        ans.rdata <= hold_reg.write ? 32'h0000_0000 : dn_rdata;
        // reserved space is the master's duty; flag it only
        ans.error <= (region_reg == access_timing_pkg::reg_none);
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  logic [4:0] span_reg; // cycles since the access was taken
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      span_reg <= 5'h00;
    end else if (state_reg == st_idle) begin
      span_reg <= 5'h00;
    end else if (span_reg != 5'h1F) begin
      span_reg <= span_reg + 5'h01;
    end
  end

  sequence taken_s;
    state_reg == st_idle && req_valid;
  endsequence

  chk_low_two_cycles: assert property (
    @(posedge clock) disable iff (!resetn)
    (taken_s and region_dec == access_timing_pkg::reg_syslow &&
     !req.wide) ##1 !contention
    |=> state_reg == st_done)
    else $error("low region access not two cycles");

  chk_sysctl_four: assert property (
    @(posedge clock) disable iff (!resetn)
    (taken_s and region_dec == access_timing_pkg::reg_sysctl &&
     !req.wide) ##1 (!contention) [*3]
    |=> state_reg == st_done)
    else $error("system control access not four cycles");

  chk_eq_three: assert property (
    @(posedge clock) disable iff (!resetn)
    (taken_s and region_dec == access_timing_pkg::reg_perif &&
     pclk_equal && !req.wide) ##1 (!contention && pclk_equal) [*2]
    |=> state_reg == st_done)
    else $error("equal clock access not three cycles");

  chk_wait_before_ans: assert property (
    @(posedge clock) disable iff (!resetn)
    $rose(ans_valid) |-> $past(state_reg) == st_done)
    else $error("answer without completed wait");

  chk_ans_one_pulse: assert property (
    @(posedge clock) disable iff (!resetn)
    ans_valid |=> !ans_valid)
    else $error("answer lasted more than one cycle");

  chk_contention_holds: assert property (
    @(posedge clock) disable iff (!resetn)
    state_reg == st_wait && contention |=> $stable(count_reg))
    else $error("count moved under contention");

  chk_pclk_counts: assert property (
    @(posedge clock) disable iff (!resetn)
    state_reg == st_wait && use_pclk_reg && !pclk_equal && !pclk_tick
    |=> $stable(count_reg))
    else $error("peripheral count moved without pclk edge");

  chk_fast_bound: assert property (
    @(posedge clock) disable iff (!resetn)
    ans_valid && use_pclk_reg && !pclk_equal
    |-> span_reg >= 5'(access_timing_pkg::pclk_fast_max))
    else $error("access answered too early");

  chk_strobe_then_ans: assert property (
    @(posedge clock) disable iff (!resetn)
    dn_strobe |-> ##1 ans_valid)
    else $error("strobe not followed by answer");

endmodule // peripheral_access_timing

`default_nettype wire

// ---- logic/access_timing_pkg.sv ----
/*
  access_timing_pkg: region bases, limits, wait counts and the carrier
  structs for the peripheral access timing bridge.
  assumes: included before any design file that names it.
*/
`default_nettype none

package access_timing_pkg;

  // ------------------------------------------------------------------
  // region bounds
  // ------------------------------------------------------------------
  localparam logic [31:0] sys_low_base    = 32'h4000_0000;
  localparam logic [31:0] sys_low_limit   = 32'h4001_BFFF;
  localparam logic [31:0] memctl_base     = 32'h4000_2000;
  localparam logic [31:0] sysctl_base     = 32'h4001_E000;
  localparam logic [31:0] sysctl_limit    = 32'h4001_EFFF;
  localparam logic [31:0] port_base       = 32'h4004_0000;
  localparam logic [31:0] pinfn_base      = 32'h4004_0800;
  localparam logic [31:0] evlink_base     = 32'h4004_1000;
  localparam logic [31:0] port_limit      = 32'h4004_1FFF;
  localparam logic [31:0] perif_base      = 32'h4004_2000;
  localparam logic [31:0] perif_limit     = 32'h4005_FFFF;

  // ------------------------------------------------------------------
  // cycle counts
  // ------------------------------------------------------------------
  localparam logic [3:0] sys_low_cycles   = 4'h2; // core clocks
  localparam logic [3:0] sysctl_cycles    = 4'h4; // core clocks
  localparam logic [3:0] pclk_eq_cycles   = 4'h3; // pclk b, equal clocks
  localparam logic [3:0] pclk_fast_min    = 4'h2; // pclk b, core faster
  localparam logic [3:0] pclk_fast_max    = 4'h4;
  localparam logic [3:0] wide_reg_extra   = 4'h2; // 16-bit data regs
  localparam logic [3:0] sync_min_extra   = 4'h1; // least added sync
  localparam logic [3:0] count_reset      = 4'h0;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;   // byte address
    logic        write;  // 1 write, 0 read
    logic [31:0] wdata;  // write data
    logic        wide;   // 16-bit data register target
  } request_type;

  typedef struct packed {
    logic [31:0] rdata;  // read data
    logic        error;  // unmapped region
  } answer_type;

  typedef enum logic [2:0] {
    reg_none   = 3'h0,
    reg_syslow = 3'h1,
    reg_sysctl = 3'h2,
    reg_port   = 3'h3,
    reg_perif  = 3'h4
  } region_type;

endpackage

`default_nettype wire

// ---- logic/region_decoder.sv ----
/*
  region_decoder: pure address decode into an access region and whether
  the address falls in the port / pin-function read-wait window.
  assumes: address is a full 32-bit byte address.
*/
`timescale 1ns/1ps
`default_nettype none

module region_decoder (
  input  wire logic [31:0]                      addr,        // byte address
  output access_timing_pkg::region_type         region,      // decoded region
  output logic                                  port_window  // port/pin fn
);

  // ------------------------------------------------------------------
  // decode, each region starts at its base address
  // ------------------------------------------------------------------
  always_comb begin
    region      = access_timing_pkg::reg_none;
    port_window = 1'b0;
    if (addr >= access_timing_pkg::sys_low_base &&
        addr <= access_timing_pkg::sys_low_limit) begin
      region = access_timing_pkg::reg_syslow;
    end else if (addr >= access_timing_pkg::sysctl_base &&
                 addr <= access_timing_pkg::sysctl_limit) begin
      region = access_timing_pkg::reg_sysctl;
    end else if (addr >= access_timing_pkg::port_base &&
                 addr <= access_timing_pkg::port_limit) begin
      region = access_timing_pkg::reg_port;
      // event link sits above the port and pin-function blocks
      port_window = (addr < access_timing_pkg::evlink_base);
    end else if (addr >= access_timing_pkg::perif_base &&
                 addr <= access_timing_pkg::perif_limit) begin
      region = access_timing_pkg::reg_perif;
    end
  end

endmodule // region_decoder

`default_nettype wire

// ---- bench/bank_model.sv ----
/*
  bank_model: downstream register banks seen from the bridge. answers
  a strobed access with data derived from its address.
  assumes: dn_req holds while dn_strobe and the cycle after it stand.
*/
`timescale 1ns/1ps
`default_nettype none

module bank_model (
  input  wire logic                           clock,     // core clock
  input  wire logic                           resetn,    // async, low
  input  wire logic                           dn_strobe, // bank strobe
  input  wire access_timing_pkg::request_type dn_req,    // bank request
  output logic [31:0]                         dn_rdata   // bank data
);
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  logic        strobe_reg; // strobe seen last cycle
  logic [31:0] churn_reg;  // changes every cycle; read only outside answers

  // remember the strobe so data also stands the cycle after it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strobe_reg <= 1'b0;
      churn_reg  <= 32'h0000_0000;
    end else begin
      strobe_reg <= dn_strobe;
      churn_reg  <= ~churn_reg + 32'h0001_0003;
    end
  end

  // data is valid only around a strobe; otherwise a moving pattern, so
  // a bridge sampling at the wrong cycle picks up garbage
  always_comb begin
    if (dn_strobe || strobe_reg) begin
      dn_rdata = dn_req.addr ^ 32'h5A5A_A5A5;
    end else begin
      dn_rdata = churn_reg;
    end
  end
endmodule // bank_model

`default_nettype wire

// ---- bench/peripheral_access_timing_bench.sv ----
/*
  peripheral_access_timing_bench: drives accesses from the master side,
  notes each expected answer in a queue; a monitor compares answers.
  assumes: package, design and bank model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_errors++; $display("unexpected %s expected %h seen %h", nm, ex, got); end end

module peripheral_access_timing_bench;
  typedef struct {
    access_timing_pkg::request_type rq;   // request as sent
    logic                           err;  // error flag expected
    int                             nmin; // least wait count
    int                             nmax; // most wait count
  } note_type;

  // -------------------------------------------------------------------
  // signals
  // -------------------------------------------------------------------
  logic                           clock      = 1'b0;
  logic                           resetn     = 1'b0;
  logic                           pclk_tick  = 1'b1;
  logic                           pclk_equal = 1'b1;
  logic                           contention = 1'b0;
  logic [3:0]                     port_read_wait_count = 4'h0;
  logic                           req_valid  = 1'b0;
  access_timing_pkg::request_type req        = '0;
  logic                           req_ready;
  logic                           ans_valid;
  access_timing_pkg::answer_type  ans;
  logic                           dn_strobe;
  access_timing_pkg::request_type dn_req;
  logic [31:0]                    dn_rdata;
  logic                           slow       = 1'b0; // half-rate ticks
  integer                         seed       = 47;
  int                             n_errors   = 0;
  int                             cmp_count  = 0;
  int                             lat        = 0;    // cycles since ready
  note_type                       notes[$];          // expected answers
  logic [31:0] addrs [14] = '{32'h4000_0000, 32'h4000_2000,
    32'h4001_BFFF, 32'h4001_C000, 32'h4001_E000, 32'h4001_EFFF,
    32'h4004_0000, 32'h4004_0800, 32'h4004_1000, 32'h4004_1FFF,
    32'h4004_2000, 32'h4005_FFFF, 32'h4006_0000, 32'h3FFF_FFFC};

  always #5 clock = ~clock;

  // peripheral clock b edges: every cycle, or every other in slow mode
  always @(posedge clock) #1 pclk_tick = slow ? ~pclk_tick : 1'b1;

  peripheral_access_timing u_dut (
    .clock(clock), .resetn(resetn), .pclk_tick(pclk_tick),
    .pclk_equal(pclk_equal), .contention(contention),
    .port_read_wait_count(port_read_wait_count), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .ans_valid(ans_valid), .ans(ans),
    .dn_strobe(dn_strobe), .dn_req(dn_req), .dn_rdata(dn_rdata));

  bank_model u_bank (.clock(clock), .resetn(resetn), .dn_strobe(dn_strobe),
    .dn_req(dn_req), .dn_rdata(dn_rdata));

  // -------------------------------------------------------------------
  // driver: one access, expectation worked out from region and mode
  // -------------------------------------------------------------------
  task automatic access(input logic [31:0] a, input logic wr,
                        input int ctn);
    note_type   nt;
    int         n;
    int         k;
    logic [3:0] wait_v;
    wait_v = 4'(($random(seed) & 32'h7FFF_FFFF) % 10);
    nt.rq = '{addr: a, write: wr, wdata: 32'($random(seed)),
              wide: 1'($random(seed))};
    nt.err = 1'b0;
    if (a >= access_timing_pkg::sys_low_base &&
        a <= access_timing_pkg::sys_low_limit) n = 2;
    else if (a >= access_timing_pkg::sysctl_base &&
             a <= access_timing_pkg::sysctl_limit) n = 4;
    else if (a >= access_timing_pkg::port_base &&
             a <= access_timing_pkg::perif_limit)
      n = pclk_equal ? 3 : 4;
    else begin
      n = 2;
      nt.err = 1'b1;
    end
    // the bridge adds the wide extra whatever the region, unmapped too
    if (nt.rq.wide) n = n + 2;
    if (!wr && a >= access_timing_pkg::port_base &&
        a < access_timing_pkg::evlink_base) n = n + int'(wait_v);
    // slow ticks stretch by up to one cycle per count, plus phase
    nt.nmin = n + ((ctn > 0) ? 1 : 0);
    nt.nmax = (slow ? 2 * n + 1 : n) + ctn;
    port_read_wait_count = wait_v;
    req = nt.rq;
    req_valid = 1'b1;
    notes.push_back(nt);
    k = 0;
    do begin
      @(posedge clock);
      #1 k++;
    end while (req_ready !== 1'b1 && k < 50);
    req_valid = 1'b0;
    contention = (ctn > 0);
    k = 0;
    do begin
      @(posedge clock);
      #1 k++;
      if (k >= ctn) contention = 1'b0;
    end while (ans_valid !== 1'b1 && k < 50);
    `CHECK("answer arrives", 1'b1, ans_valid)
  endtask

  // -------------------------------------------------------------------
  // monitor: takes the oldest note whenever an answer appears
  // -------------------------------------------------------------------
  always @(posedge clock) begin : monitor
    note_type nt;
    lat = lat + 1;
    if (req_ready === 1'b1) lat = 0;
    if (dn_strobe === 1'b1 && notes.size() > 0)
      `CHECK("bank request", notes[0].rq, dn_req)
    if (ans_valid === 1'b1) begin
      if (notes.size() == 0) `CHECK("spurious answer", 1'b0, 1'b1)
      else begin
        nt = notes.pop_front();
        `CHECK("error flag", nt.err, ans.error)
        if (!nt.rq.write && !nt.err)
          `CHECK("read data", nt.rq.addr ^ 32'h5A5A_A5A5, ans.rdata)
        `CHECK("wait in span", 1'b1, lat >= nt.nmin && lat <= nt.nmax)
      end
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------------------------
  initial begin : main
    int i;
    repeat (5) @(posedge clock);
    #1 resetn = 1'b1;
    @(posedge clock);
    #1;
    // equal clocks, then core faster with a tick every cycle
    for (i = 0; i < 2; i++) begin
      pclk_equal = (i == 0);
      foreach (addrs[j]) begin
        access(addrs[j], 1'b0, 0);
        access(addrs[j], 1'b1, 0);
      end
    end
    slow = 1'b1;
    access(32'h4004_4200, 1'b0, 0);
    access(32'h4004_0800, 1'b0, 0);
    slow = 1'b0;
    pclk_equal = 1'b1;
    access(32'h4004_4600, 1'b0, 2);
    access(32'h4001_E010, 1'b1, 3);
    report_and_stop();
  end

  initial begin : watchdog
    repeat (5000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end
endmodule // peripheral_access_timing_bench

`default_nettype wire
